// [hw/lpw_pkg.sv]
`default_nettype none
package lpw_pkg;
    // APB byte offsets
    localparam logic [7:0] LPW_CTRL_OFS = 8'h00;
    localparam logic [7:0] LPW_QPRD_OFS = 8'h04;
    localparam logic [7:0] LPW_QSEL_OFS = 8'h08;
    localparam logic [7:0] LPW_WKEN_OFS = 8'h0C;
    localparam logic [7:0] LPW_STAT_OFS = 8'h10;

    // Control register fields
    localparam int LPW_MODE_POS = 0;
    localparam int LPW_SQC_POS = 2;
    localparam int LPW_SQC_W = 6;
    localparam int LPW_DIV_POS = 8;
    localparam int LPW_FSLP_POS = 10;
    localparam int LPW_SQEN_POS = 11;
    localparam int LPW_WIEN_POS = 12;
    localparam logic [31:0] LPW_CTRL_RST = 32'h0000_0000;
    localparam logic [7:0] LPW_QPRD_RST = 8'h00;

    // Qualifier select encodings
    localparam logic [1:0] LPW_QS_SYNC = 2'h0;
    localparam logic [1:0] LPW_QS_3SMP = 2'h1;
    localparam logic [1:0] LPW_QS_6SMP = 2'h2;
    localparam logic [1:0] LPW_QS_ASYNC = 2'h3;
    localparam int LPW_N3 = 3;
    localparam int LPW_N6 = 6;

    // Sequencer cycle counts, system clock
    localparam logic [6:0] LPW_FLUSH_16 = 7'h10;
    localparam logic [6:0] LPW_FLUSH_32 = 7'h20;
    localparam logic [6:0] LPW_FLUSH_64 = 7'h40;
    localparam logic [6:0] LPW_XCLK_LOW = 7'h20;
    localparam logic [10:0] LPW_IDLE_LAT = 11'h014;
    localparam logic [10:0] LPW_IDLE_LAT_FS = 11'h41A;
    localparam logic [10:0] LPW_STBY_LAT = 11'h064;
    localparam logic [10:0] LPW_STBY_LAT_FS = 11'h465;
    // Standby wake, oscillator ticks
    localparam logic [6:0] LPW_SWAKE_RAW = 7'h03;
    localparam logic [6:0] LPW_SWAKE_BASE = 7'h02;

    typedef enum logic [2:0] {
        LPW_RUN = 3'h0,
        LPW_FLUSH = 3'h1,
        LPW_STBY = 3'h3,
        LPW_WAKE = 3'h2,
        LPW_IDLE = 3'h6
    } lpw_state_t;

    typedef struct packed {
        logic wake_irq_en;
        logic stby_qual_en;
        logic flash_sleep;
        logic [1:0] divider_select;
        logic [5:0] standby_qualifier_count;
        logic [1:0] lp_mode;
    } lpw_ctrl_t;
endpackage
`default_nettype wire

// [hw/lpw_qual.sv]
`default_nettype none
module lpw_qual
    import lpw_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic pin,
    input wire logic sample_tick,
    input wire logic [1:0] qsel,
    output logic qual_out
);
    logic sync1_q;
    logic sync2_q;
    logic [LPW_N6-1:0] smp_q;
    logic held_q;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= pin;
            sync2_q <= sync1_q;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            smp_q <= '0;
        end else if (sample_tick) begin
            smp_q <= {smp_q[LPW_N6-2:0], sync2_q};
        end
    end

    // Window holds its value until every sample agrees
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            held_q <= 1'b0;
        end else if (qsel == LPW_QS_3SMP) begin
            if (&smp_q[LPW_N3-1:0]) begin // R3 R4 R18
                held_q <= 1'b1;
            end else if (~|smp_q[LPW_N3-1:0]) begin // R18
                held_q <= 1'b0;
            end
        end else if (qsel == LPW_QS_6SMP) begin
            if (&smp_q) begin // R3 R5 R18
                held_q <= 1'b1;
            end else if (~|smp_q) begin // R18
                held_q <= 1'b0;
            end
        end else begin
            held_q <= sync2_q;
        end
    end

    always_comb begin
        case (qsel)
            LPW_QS_SYNC: qual_out = sync2_q; // R19
            LPW_QS_ASYNC: qual_out = pin; // R19
            default: qual_out = held_q;
        endcase
    end
endmodule
`default_nettype wire

// [hw/lpw_top.sv]
// Functional notes
// R1: Nonzero period samples every 2*period cycles.
// R2: Zero period samples every system cycle.
// R3: Per pin, three or six samples chosen.
// R4: Three-sample window spans two periods.
// R5: Six-sample window spans five periods.
// R6: Idle wake pulse width met by source.
// R7: Idle exit within 20 or 1050 cycles.
// R8: Idle exits on interrupt, watchdog or reset.
// R9: Source waits five oscillator cycles before waking.
// R10: Standby wake pulse width met by source.
// R11: External clock low 32-45 cycles after entry.
// R12: Standby exit within 100 or 1125 cycles.
// R13: Flush delay 16/32/64 by divider select.
// R14: Standby stops peripherals, keeps PLL, watchdog.
// R15: Wake pins must be glitch free.
// R16: Resume marks next instruction start.
// R17: After standby, service enabled wake interrupt.
// R18: Qualified input changes only when samples agree.
// R19: Select 00 sync only default; 11 bypass.
// R20: Mode field picks idle or standby.
//
// The APB slave port and the placing of the registers are this design's own decisions.
`default_nettype none
module lpw_top
    import lpw_pkg::*;
#(
    parameter int NPINS = 8
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NPINS-1:0] gpio_in,
    input wire logic osc_clk_in,
    input wire logic lpm_enter,
    input wire logic irq_pending,
    input wire logic watchdog_interrupt,
    input wire logic external_reset_input,
    output logic [NPINS-1:0] qual_in,
    output logic core_clk_en,
    output logic periph_clk_en,
    output logic pll_en,
    output logic watchdog_clk_en,
    output logic ext_clk_hold_low,
    output logic cpu_resume,
    output logic wake_irq
);
    generate
        if (NPINS < 1 || NPINS > 16) begin : g_chk
            $error("NPINS must be 1 to 16");
        end
    endgenerate

    lpw_ctrl_t ctrl_q;
    logic [7:0] qprd_q;
    logic [2*NPINS-1:0] qsel_q;
    logic [NPINS-1:0] wken_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic [8:0] tick_cnt_q;
    logic sample_tick;
    lpw_state_t state_q;
    logic [6:0] ent_cnt_q;
    logic [10:0] lat_cnt_q;
    logic [10:0] lat_lim_q;
    logic xclk_low_q;
    logic resume_q;
    logic wirq_q;
    logic stby_exit_q;
    logic osc1_q;
    logic osc2_q;
    logic osc3_q;
    logic [6:0] swk_cnt_q;
    logic wake_pin;
    logic wake_any;
    logic stby_wake;
    logic osc_rise;
    logic [6:0] flush_lim;
    logic [6:0] swk_lim;
    logic wr_en;
    logic rd_en;
    logic addr_ok;

    // APB slave, zero wait states
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & ~penable & ~pwrite;
    assign addr_ok = (paddr == LPW_CTRL_OFS) || (paddr == LPW_QPRD_OFS) ||
        (paddr == LPW_QSEL_OFS) || (paddr == LPW_WKEN_OFS) ||
        (paddr == LPW_STAT_OFS);
    assign pready = 1'b1;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q & psel & penable;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ctrl_q <= lpw_ctrl_t'(LPW_CTRL_RST[12:0]);
            qprd_q <= LPW_QPRD_RST;
            qsel_q <= '0; // R19
            wken_q <= '0;
        end else if (wr_en) begin
            case (paddr)
                LPW_CTRL_OFS: ctrl_q <= lpw_ctrl_t'(pwdata[12:0]);
                LPW_QPRD_OFS: qprd_q <= pwdata[7:0];
                LPW_QSEL_OFS: qsel_q <= pwdata[2*NPINS-1:0];
                LPW_WKEN_OFS: wken_q <= pwdata[NPINS-1:0];
                default: ;
            endcase
        end
    end

    // Read data captured in setup so it stands through access
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            prdata_q <= '0;
            pslverr_q <= 1'b0;
        end else if (psel & ~penable) begin
            pslverr_q <= ~addr_ok;
            prdata_q <= '0;
            if (rd_en) begin
                case (paddr)
                    LPW_CTRL_OFS: prdata_q <= {19'h0, ctrl_q};
                    LPW_QPRD_OFS: prdata_q <= {24'h0, qprd_q};
                    LPW_QSEL_OFS: prdata_q <= 32'(qsel_q);
                    LPW_WKEN_OFS: prdata_q <= 32'(wken_q);
                    LPW_STAT_OFS: prdata_q <= {13'h0, state_q,
                        16'(qual_in)};
                    default: prdata_q <= '0;
                endcase
            end
        end
    end

    // Sample strobe shared by all qualifiers
    assign sample_tick = (qprd_q == 8'h00) || // R2
        (tick_cnt_q == {qprd_q, 1'b0} - 9'h001); // R1
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            tick_cnt_q <= '0;
        end else if (sample_tick) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 9'h001;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NPINS; gi++) begin : g_q
            lpw_qual u_qual (
                .mclk(mclk),
                .reset(reset),
                .pin(gpio_in[gi]),
                .sample_tick(sample_tick),
                .qsel(qsel_q[2*gi+1:2*gi]), // R3
                .qual_out(qual_in[gi])
            );
        end
    endgenerate

    assign wake_pin = |(qual_in & wken_q);
    assign wake_any = wake_pin | irq_pending | watchdog_interrupt |
        external_reset_input; // R8

    // Oscillator clock sampled as a level; rising edges count ticks
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            osc1_q <= 1'b0;
            osc2_q <= 1'b0;
            osc3_q <= 1'b0;
        end else begin
            osc1_q <= osc_clk_in;
            osc2_q <= osc1_q;
            osc3_q <= osc2_q;
        end
    end
    assign osc_rise = osc2_q & ~osc3_q;

    // Standby wake qualified in oscillator ticks
    assign swk_lim = ctrl_q.stby_qual_en ?
        LPW_SWAKE_BASE + {1'b0, ctrl_q.standby_qualifier_count} :
        LPW_SWAKE_RAW;
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            swk_cnt_q <= '0;
        end else if (state_q != LPW_STBY || !wake_any) begin
            swk_cnt_q <= '0;
        end else if (osc_rise && swk_cnt_q != swk_lim) begin
            swk_cnt_q <= swk_cnt_q + 7'h01;
        end
    end
    assign stby_wake = (state_q == LPW_STBY) &&
        (swk_cnt_q == swk_lim); // R10

    always_comb begin
        case (ctrl_q.divider_select)
            2'h2: flush_lim = LPW_FLUSH_32; // R13
            2'h3: flush_lim = LPW_FLUSH_64; // R13
            default: flush_lim = LPW_FLUSH_16; // R13
        endcase
    end

    // Low-power sequencer
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_q <= LPW_RUN;
        end else begin
            case (state_q)
                LPW_RUN: begin
                    if (lpm_enter) begin
                        state_q <= ctrl_q.lp_mode[0] ? LPW_FLUSH :
                            LPW_IDLE; // R20
                    end
                end
                LPW_FLUSH: begin
                    if (ent_cnt_q >= flush_lim - 7'h01) begin
                        state_q <= LPW_STBY; // R13
                    end
                end
                LPW_STBY: begin
                    if (stby_wake) begin
                        state_q <= LPW_WAKE;
                    end
                end
                LPW_IDLE: begin
                    if (wake_any) begin
                        state_q <= LPW_WAKE; // R8
                    end
                end
                LPW_WAKE: begin
                    if (lat_cnt_q >= lat_lim_q - 11'h001) begin
                        state_q <= LPW_RUN; // R20
                    end
                end
                default: state_q <= LPW_RUN;
            endcase
        end
    end

    // Cycles since entry, drives flush and clock-out hold
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ent_cnt_q <= '0;
        end else if (state_q == LPW_RUN || state_q == LPW_WAKE ||
                     state_q == LPW_IDLE) begin
            ent_cnt_q <= '0;
        end else if (ent_cnt_q != 7'h7F) begin
            ent_cnt_q <= ent_cnt_q + 7'h01;
        end
    end

    // Fixed at cycle 32; inside the 32..45 window for every divider
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            xclk_low_q <= 1'b0;
        end else begin
            xclk_low_q <= (state_q == LPW_FLUSH || state_q == LPW_STBY) &&
                ent_cnt_q >= LPW_XCLK_LOW - 7'h02; // R11
        end
    end

    // Latency limit chosen at wake; flash sleep costs the long path
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            lat_lim_q <= LPW_IDLE_LAT;
            stby_exit_q <= 1'b0;
        end else if (state_q == LPW_IDLE && wake_any) begin
            lat_lim_q <= ctrl_q.flash_sleep ? LPW_IDLE_LAT_FS :
                LPW_IDLE_LAT; // R7
            stby_exit_q <= 1'b0;
        end else if (stby_wake) begin
            lat_lim_q <= ctrl_q.flash_sleep ? LPW_STBY_LAT_FS :
                LPW_STBY_LAT; // R12
            stby_exit_q <= 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            lat_cnt_q <= '0;
        end else if (state_q == LPW_WAKE) begin
            lat_cnt_q <= lat_cnt_q + 11'h001;
        end else begin
            lat_cnt_q <= '0;
        end
    end

    // Resume pulse marks start of the next instruction
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            resume_q <= 1'b0;
            wirq_q <= 1'b0;
        end else begin
            resume_q <= state_q == LPW_WAKE &&
                lat_cnt_q >= lat_lim_q - 11'h001; // R16
            wirq_q <= state_q == LPW_WAKE &&
                lat_cnt_q >= lat_lim_q - 11'h001 &&
                stby_exit_q && ctrl_q.wake_irq_en; // R17
        end
    end

    assign cpu_resume = resume_q;
    assign wake_irq = wirq_q;
    assign ext_clk_hold_low = xclk_low_q;
    assign core_clk_en = state_q == LPW_RUN || state_q == LPW_FLUSH;
    assign periph_clk_en = state_q != LPW_STBY; // R14
    assign pll_en = 1'b1; // R14
    assign watchdog_clk_en = 1'b1; // R14
endmodule
`default_nettype wire

// [tb/lpw_top_sva.sv]
`default_nettype none
module lpw_chk
    import lpw_pkg::*;
#(
    parameter int NPINS = 8
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [NPINS-1:0] gpio_in,
    input wire logic lpm_enter,
    input wire logic irq_pending,
    input wire logic [NPINS-1:0] qual_in,
    input wire logic core_clk_en,
    input wire logic periph_clk_en,
    input wire logic pll_en,
    input wire logic watchdog_clk_en,
    input wire logic ext_clk_hold_low,
    input wire logic cpu_resume,
    input wire logic wake_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] ctrl_q;
    logic [31:0] qsel_q;
    logic [7:0] qprd_q;
    logic busy_q;
    logic [7:0] ent_q;
    logic [7:0] fl_n;
    logic wr;
    logic ent;
    assign wr = psel && penable && pwrite;
    assign ent = lpm_enter && !busy_q;
    assign fl_n = ctrl_q[9] ? (ctrl_q[8] ? 8'h40 : 8'h20) : 8'h10;
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    // Shadow of the programmed settings, seen from the bus alone
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ctrl_q <= 32'h0;
            qsel_q <= 32'h0;
            qprd_q <= 8'h0;
        end else if (wr) begin
            if (paddr == LPW_CTRL_OFS) ctrl_q <= pwdata;
            if (paddr == LPW_QSEL_OFS) qsel_q <= pwdata;
            if (paddr == LPW_QPRD_OFS) qprd_q <= pwdata[7:0];
        end
    end
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            busy_q <= 1'h0;
            ent_q <= 8'h0;
        end else if (ent) begin
            busy_q <= 1'h1;
            ent_q <= 8'h01;
        end else begin
            if (cpu_resume) busy_q <= 1'h0;
            if (busy_q && ent_q != 8'hFF) ent_q <= ent_q + 8'h01;
        end
    end
    chk_pll_wdog_on: assert property (pll_en && watchdog_clk_en)
        else $error("pll or watchdog clock stopped");
    chk_stby_clocks: assert property (!periph_clk_en |-> !core_clk_en)
        else $error("peripheral clock off while core runs");
    chk_idle_gate: assert property (ent && !ctrl_q[0] |=> !core_clk_en)
        else $error("idle entry did not gate core clock");
    chk_flush_len: assert property (
        busy_q && ctrl_q[0] && $fell(core_clk_en) |->
        ent_q >= fl_n && ent_q <= fl_n + 8'h02)
        else $error("flush length wrong");
    chk_xclk_delay: assert property (
        busy_q && $rose(ext_clk_hold_low) |-> ent_q >= 8'h20 && ent_q <= 8'h2D)
        else $error("external clock low outside window");
    chk_idle_wake: assert property (
        busy_q && !core_clk_en && ctrl_q[1:0] == 2'h0 && !ctrl_q[10]
        && $rose(irq_pending) |-> ##[1:26] cpu_resume)
        else $error("idle exit too slow");
    chk_resume_pulse: assert property (cpu_resume |=> !cpu_resume)
        else $error("resume pulse too long");
    chk_wirq_pair: assert property (
        wake_irq |-> cpu_resume && ctrl_q[LPW_WIEN_POS] && ctrl_q[0])
        else $error("wake interrupt without standby resume");
    chk_sync_only: assert property (
        qsel_q[7:6] == LPW_QS_SYNC |-> qual_in[3] == $past(gpio_in[3], 2))
        else $error("sync path delay wrong");
    chk_qual_agree: assert property (
        qsel_q[3:2] == LPW_QS_3SMP && qprd_q == 8'h0 && $changed(qual_in[1])
        |-> $past(gpio_in[1], 4) == qual_in[1]
        && $past(gpio_in[1], 5) == qual_in[1]
        && $past(gpio_in[1], 6) == qual_in[1])
        else $error("qualified input changed on mixed samples");
    cov_stby: cover property (ent && ctrl_q[0]);
    cov_wirq: cover property (wake_irq);
    cov_qual: cover property ($changed(qual_in[1]));
endmodule
bind lpw_top lpw_chk #(.NPINS(NPINS)) u_lpw_chk (.mclk(mclk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .gpio_in(gpio_in), .lpm_enter(lpm_enter),
    .irq_pending(irq_pending), .qual_in(qual_in), .core_clk_en(core_clk_en),
    .periph_clk_en(periph_clk_en), .pll_en(pll_en),
    .watchdog_clk_en(watchdog_clk_en), .ext_clk_hold_low(ext_clk_hold_low),
    .cpu_resume(cpu_resume), .wake_irq(wake_irq));
`default_nettype wire

// [tb/lpw_wake_src.sv]
`default_nettype none
module lpw_wake_src (
    input wire logic mclk,
    input wire logic start,
    input wire logic [3:0] width,
    output logic osc,
    output logic pin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] div_q = 2'h0;
    logic [4:0] cnt_q = 5'h00;
    logic run_q = 1'h0;
    // Oscillator runs free, a quarter of the system rate
    always_ff @(posedge mclk) div_q <= div_q + 2'h1;
    assign osc = div_q[1];
    // Clean single pulse: one rise, one fall, no glitches
    assign pin = run_q && cnt_q >= 5'h05 &&
        cnt_q < 5'h05 + {1'h0, width};
    always_ff @(posedge mclk) begin
        if (start && !run_q) begin
            run_q <= 1'h1;
            cnt_q <= 5'h00;
        end else if (run_q && div_q == 2'h1) begin
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == 5'h05 + {1'h0, width}) run_q <= 1'h0;
        end
    end
endmodule
`default_nettype wire

// [tb/lpw_top_test.sv]
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; \
    $display("CHECK FAILED t=%0t got %0h", $time, (a)); end end
module lpw_top_test
    import lpw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk, reset, psel, penable, pwrite, pready, pslverr, osc, wk_pin;
    logic [7:0] paddr, gpio, qual_in;
    logic [31:0] pwdata, prdata, rd;
    logic lpm_enter, irq_pending, watchdog_interrupt, external_reset_input;
    logic core_clk_en, periph_clk_en, pll_en, watchdog_clk_en;
    logic ext_clk_hold_low, cpu_resume, wake_irq, wk_start, er;
    logic [3:0] wk_width;
    int err_total, n_compared;
    lpw_top u_lpw_top (.mclk(mclk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .gpio_in({gpio[7:4], wk_pin, gpio[2:0]}), .osc_clk_in(osc),
        .lpm_enter(lpm_enter), .irq_pending(irq_pending),
        .watchdog_interrupt(watchdog_interrupt),
        .external_reset_input(external_reset_input), .qual_in(qual_in),
        .core_clk_en(core_clk_en), .periph_clk_en(periph_clk_en),
        .pll_en(pll_en), .watchdog_clk_en(watchdog_clk_en),
        .ext_clk_hold_low(ext_clk_hold_low), .cpu_resume(cpu_resume),
        .wake_irq(wake_irq));
    lpw_wake_src u_lpw_wake_src (.mclk(mclk), .start(wk_start),
        .width(wk_width), .osc(osc), .pin(wk_pin));
    always #50 mclk = ~mclk;
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic enter();
        @(posedge mclk);
        lpm_enter <= 1'h1;
        @(posedge mclk);
        lpm_enter <= 1'h0;
    endtask
    task automatic wait_resume(input int lim, output int n);
        n = 0;
        while (cpu_resume !== 1'h1 && n < lim) begin
            @(negedge mclk);
            n++;
        end
    endtask
    task automatic t_regs();
        apb(1'h0, LPW_CTRL_OFS, 32'h0);
        `CHK(rd, LPW_CTRL_RST)
        apb(1'h0, LPW_QSEL_OFS, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'h1, LPW_QPRD_OFS, 32'hA5);
        apb(1'h0, LPW_QPRD_OFS, 32'h0);
        `CHK({er, rd[7:0]}, 9'h0A5)
        apb(1'h0, 8'h40, 32'h0);
        `CHK(er, 1'h1)
        `CHK(pready, 1'h1)
        apb(1'h1, LPW_QPRD_OFS, 32'h0);
        $display("test regs done");
    endtask
    task automatic t_qual();
        apb(1'h1, LPW_QSEL_OFS, 32'h27);
        @(posedge mclk) gpio[0] <= 1'h1;
        cyc(1);
        `CHK(qual_in[0], 1'h1)
        @(posedge mclk) gpio[1] <= 1'h1;
        @(posedge mclk) gpio[1] <= 1'h0;
        cyc(8);
        `CHK(qual_in[1], 1'h0)
        @(posedge mclk) gpio[1] <= 1'h1;
        cyc(5);
        `CHK(qual_in[1], 1'h0)
        cyc(3);
        `CHK(qual_in[1], 1'h1)
        apb(1'h1, LPW_QPRD_OFS, 32'h1);
        @(posedge mclk) gpio[2] <= 1'h1;
        cyc(6);
        @(posedge mclk) gpio[2] <= 1'h0;
        cyc(20);
        `CHK(qual_in[2], 1'h0)
        @(posedge mclk) gpio[2] <= 1'h1;
        cyc(9);
        `CHK(qual_in[2], 1'h0)
        cyc(12);
        `CHK(qual_in[2], 1'h1)
        apb(1'h0, LPW_STAT_OFS, 32'h0);
        `CHK(rd, 32'h7)
        $display("test qual done");
    endtask
    task automatic t_idle();
        int n;
        for (int s = 0; s < 4; s++) begin
            apb(1'h1, LPW_CTRL_OFS, s == 3 ? 32'h400 : 32'h0);
            enter();
            cyc(1);
            `CHK(core_clk_en, 1'h0)
            cyc(24);
            @(posedge mclk);
            {external_reset_input, watchdog_interrupt, irq_pending} <=
                3'h1 << (s % 3);
            wait_resume(1200, n);
            if (s == 3) `CHK(n > 1000 && n <= 1056, 1'h1)
            else `CHK(n <= 26, 1'h1)
            `CHK(wake_irq, 1'h0)
            @(posedge mclk);
            {external_reset_input, watchdog_interrupt, irq_pending} <= 3'h0;
        end
        $display("test idle done");
    endtask
    task automatic t_stby();
        int f, n, k;
        logic [3:0] ck;
        logic [31:0] cv;
        apb(1'h1, LPW_WKEN_OFS, 32'h8);
        for (int d = 0; d < 4; d++) begin
            f = d == 3 ? 64 : d == 2 ? 32 : 16;
            // Pass 2 sleeps flash, no wake irq; pass 3 qualifies, count 2
            cv = d == 2 ? 32'h401 : 32'h1001;
            if (d == 3) cv = cv | 32'h808;
            apb(1'h1, LPW_CTRL_OFS, cv | (d << 8));
            enter();
            cyc(f);
            `CHK(core_clk_en, 1'h1)
            cyc(4);
            ck = {core_clk_en, periph_clk_en, pll_en, watchdog_clk_en};
            `CHK(ck, 4'h3)
            if (f < 43) cyc(43 - f);
            `CHK(ext_clk_hold_low, 1'h1)
            @(posedge mclk);
            wk_width <= 4'(3 + d);
            wk_start <= 1'h1;
            @(posedge mclk) wk_start <= 1'h0;
            k = 0;
            while (wk_pin !== 1'h1 && k < 60) begin
                @(negedge mclk);
                k++;
            end
            `CHK(wk_pin, 1'h1)
            wait_resume(1300, n);
            if (d == 2) `CHK(n > 1000 && n <= 1153, 1'h1)
            else `CHK(n <= 108 + 4 * (3 + d), 1'h1)
            `CHK(wake_irq, d != 2)
        end
        $display("test standby done");
    endtask
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        {mclk, psel, penable, pwrite, lpm_enter, wk_start} = 6'h00;
        {irq_pending, watchdog_interrupt, external_reset_input} = 3'h0;
        {paddr, gpio, pwdata, wk_width} = 52'h0;
        {err_total, n_compared} = 64'h0;
        reset = 1'h1;
        repeat (3) @(posedge mclk);
        reset <= 1'h0;
        t_regs();
        t_qual();
        t_idle();
        t_stby();
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        err_total++;
        $display("CHECK FAILED t=%0t watchdog expired", $time);
        complete_run();
    end
endmodule
`default_nettype wire
